/* mac_ctl_pkg.sv */
`default_nettype none
package mac_ctl_pkg;
  // ******************************************
  // Control register selection
  // ******************************************
  localparam logic [3:0] CSR_PHY_MIRROR = 4'hC;
  localparam logic [3:0] CSR_SAMPLE_SEL = 4'hD;
  localparam logic [3:0] CSR_FEATURE = 4'hF;
  // ******************************************
  // Status mirror layout
  // ******************************************
  localparam int MIRROR_LINK_BIT = 3;
  localparam int MIRROR_FDX_BIT = 2;
  localparam int MIRROR_100_BIT = 1;
  localparam int MIRROR_10_BIT = 0;
  localparam logic [31:0] MIRROR_FILL = 32'hFFFFFE00;
  // ******************************************
  // Sample frame selector
  // ******************************************
  localparam int SEL_LSB = 3;
  localparam int SEL_MSB = 8;
  localparam logic [5:0] SEL_TX_BUF = 6'h32;
  localparam logic [5:0] SEL_RX_BUF = 6'h35;
  localparam logic [5:0] SEL_DIAG_CLR = 6'h38;
  localparam logic [5:0] SEL_RESET = 6'h00;
  // ******************************************
  // Feature register layout
  // ******************************************
  localparam int FEAT_CSUM_DESC = 31;
  localparam int FEAT_IP_ALL = 30;
  localparam int FEAT_TCP_ALL = 29;
  localparam int FEAT_UDP_ALL = 28;
  localparam int FEAT_RX_CSUM = 27;
  localparam int FEAT_ZERO_PAUSE = 14;
  localparam int FEAT_MAX_PAUSE = 13;
  localparam int FEAT_PAUSE_DEC = 10;
  localparam int FEAT_PAUSE_SEEN = 9;
  localparam int FEAT_PAUSE_RUN = 7;
  localparam int FEAT_VLAN = 6;
  localparam int FEAT_WDOG_OFF = 4;
  localparam int FEAT_JAB_OFF = 0;
  localparam logic [31:0] FEAT_RESET = 32'h00000000;
  localparam logic [15:0] PAUSE_TIME_ZERO = 16'h0000;
  localparam logic [15:0] PAUSE_TIME_MAX = 16'hFFFF;
  localparam logic [10:0] VLAN_MAX_LEN = 11'h5F6;
  // ******************************************
  // Timing
  // ******************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int PAUSE_QUANTUM_NS = 5120;
  localparam int PAUSE_QUANTUM_CYCLES =
    (PAUSE_QUANTUM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MGMT_PREAMBLE_LEN = 32;
  // ******************************************
  // Internal PHY management map
  // ******************************************
  localparam logic [4:0] PHY_BASIC_CONTROL = 5'h00;
  localparam logic [4:0] PHY_BASIC_STATUS = 5'h01;
  localparam logic [4:0] PHY_IDENT_HIGH = 5'h02;
  localparam logic [4:0] PHY_IDENT_LOW = 5'h03;
  localparam logic [4:0] AUTONEG_ADVERTISE = 5'h04;
  localparam logic [4:0] AUTONEG_PARTNER = 5'h05;
  localparam logic [4:0] AUTONEG_EXPANSION = 5'h06;
  localparam logic [4:0] VENDOR_CONFIG = 5'h10;
  localparam logic [4:0] VENDOR_CONFIG_STATUS = 5'h11;
  localparam logic [4:0] TENBASE_CONFIG_STATUS = 5'h12;
  localparam logic [4:0] POWER_DOWN_CONTROL = 5'h13;
  localparam logic [4:0] CROSSOVER_CONTROL = 5'h14;
  localparam logic [15:0] BASIC_CONTROL_RESET = 16'h3100;
  localparam logic [15:0] BASIC_STATUS_RESET = 16'h7849;
  localparam logic [15:0] ADVERTISE_RESET = 16'h01E1;
  localparam logic [15:0] VENDOR_CONFIG_RESET = 16'h0414;
  localparam logic [15:0] VENDOR_STATUS_RESET = 16'hF210;
  localparam logic [15:0] TENBASE_RESET = 16'h7800;
  localparam logic [15:0] ZERO_RESET = 16'h0000;
  localparam int BASIC_CTRL_RESET_BIT = 15;
  localparam int BASIC_STATUS_LINK_BIT = 2;
  localparam logic [1:0] MGMT_OP_READ = 2'b10;
  localparam logic [1:0] MGMT_OP_WRITE = 2'b01;
  typedef enum {
    MG_PREAMBLE, MG_START, MG_OPCODE, MG_ADDR, MG_TURN, MG_DATA
  } mgmt_state_type;
endpackage
`default_nettype wire

/* pause_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module pause_timer #(
  parameter int QUANTUM_CYCLES = mac_ctl_pkg::PAUSE_QUANTUM_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic load,
  input wire logic [15:0] load_quanta,
  output logic running_ff
);
  import mac_ctl_pkg::*;
  logic [15:0] quanta_ff;
  logic [15:0] tick_ff;
  wire quantum_end = (tick_ff == 16'(QUANTUM_CYCLES - 1));
  wire [15:0] nxt_quanta = load ? load_quanta :
    (quantum_end && quanta_ff != 16'h0000) ? quanta_ff - 16'h0001 :
    quanta_ff;
  wire [15:0] nxt_tick = (load || quantum_end) ? 16'h0000 :
    tick_ff + 16'h0001;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      quanta_ff <= 16'h0000;
      tick_ff <= 16'h0000;
      running_ff <= 1'b0;
    end else if (ce) begin
      quanta_ff <= nxt_quanta;
      tick_ff <= nxt_tick;
      running_ff <= (nxt_quanta != 16'h0000); // R11
    end
  end
  // Flag tracks a nonzero load within one cycle
  a_load_runs: assert property (@(posedge clk) disable iff (sys_rst) // R11
    ce && load && load_quanta != 16'h0000 |=> running_ff)
    else $error("pause flag not raised after load");
endmodule
`default_nettype wire

/* phy_mgmt_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_regs #(
  parameter logic [15:0] IDENT_HIGH = 16'h1234, // Arbitrary value
  parameter logic [15:0] IDENT_LOW = 16'h5670 // Arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [4:0] addr,
  input wire logic [15:0] wdata,
  input wire logic link_up,
  output logic [15:0] rdata_ff
);
  import mac_ctl_pkg::*;
  logic [15:0] ctrl_ff, adv_ff, vcfg_ff, vstat_ff, tbase_ff, pwd_ff, crossover_control_ff;
  // Soft reset bit restores defaults then clears itself
  wire soft_rst = ctrl_ff[BASIC_CTRL_RESET_BIT]; // R19
  wire [15:0] status_now = {BASIC_STATUS_RESET[15:3], link_up,
    BASIC_STATUS_RESET[1:0]};
  logic [15:0] rd_mux;
  always_comb begin
    case (addr)
      PHY_BASIC_CONTROL: rd_mux = ctrl_ff; // R15
      PHY_BASIC_STATUS: rd_mux = status_now; // R15
      PHY_IDENT_HIGH: rd_mux = IDENT_HIGH; // R16
      PHY_IDENT_LOW: rd_mux = IDENT_LOW; // R16
      AUTONEG_ADVERTISE: rd_mux = adv_ff; // R15
      VENDOR_CONFIG: rd_mux = vcfg_ff; // R17
      VENDOR_CONFIG_STATUS: rd_mux = vstat_ff; // R17
      TENBASE_CONFIG_STATUS: rd_mux = tbase_ff; // R17
      POWER_DOWN_CONTROL: rd_mux = pwd_ff; // R17
      CROSSOVER_CONTROL: rd_mux = crossover_control_ff; // R17
      default: rd_mux = ZERO_RESET; // R16
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff <= BASIC_CONTROL_RESET;
      adv_ff <= ADVERTISE_RESET;
      vcfg_ff <= VENDOR_CONFIG_RESET;
      vstat_ff <= VENDOR_STATUS_RESET;
      tbase_ff <= TENBASE_RESET;
      pwd_ff <= ZERO_RESET;
      crossover_control_ff <= ZERO_RESET;
      rdata_ff <= ZERO_RESET;
    end else if (ce) begin
      rdata_ff <= rd_mux;
      if (soft_rst) begin
        ctrl_ff <= BASIC_CONTROL_RESET; // R19
        adv_ff <= ADVERTISE_RESET;
        vcfg_ff <= VENDOR_CONFIG_RESET;
        vstat_ff <= VENDOR_STATUS_RESET;
        tbase_ff <= TENBASE_RESET;
        pwd_ff <= ZERO_RESET;
        crossover_control_ff <= ZERO_RESET;
      end else if (wr_en) begin
        case (addr)
          PHY_BASIC_CONTROL: ctrl_ff <= wdata;
          AUTONEG_ADVERTISE: adv_ff <= wdata;
          VENDOR_CONFIG: vcfg_ff <= wdata;
          VENDOR_CONFIG_STATUS: vstat_ff <= wdata;
          TENBASE_CONFIG_STATUS: tbase_ff <= wdata;
          POWER_DOWN_CONTROL: pwd_ff <= wdata;
          CROSSOVER_CONTROL: crossover_control_ff <= wdata;
          default: ctrl_ff <= ctrl_ff;
        endcase
      end
    end
  end
  a_soft_reset: assert property (@(posedge clk) disable iff (sys_rst) // R19
    ce && soft_rst |=> ctrl_ff == BASIC_CONTROL_RESET)
    else $error("soft reset bit did not self clear");
endmodule
`default_nettype wire

/* mac_control_phy_map.sv */
// How it works
// R1: Mirror bits 3..0: link, duplex, 100M, 10M
// R2: Selector 32H/35H picks transmit/receive buffer port
// R3: Selector 38H clears diagnostic pointer, write-only
// R4: Bit 31: checksum per transmit descriptor
// R5: Bits 30..28 force IP/TCP/UDP checksum always
// R6: Bit 27 reports receive checksum; 31..27 write-only
// R7: Bit 14 sends zero pause, then self-clears
// R8: Bit 13 sends maximum pause, then self-clears
// R9: Pause frames decoded only while bit 10 set
// R10: Bit 9 latches decode, clears on read
// R11: Bit 7 high while received pause counts
// R12: VLAN mode hides too-long under 1526 bytes
// R13: Bit 4 disables receive watchdog
// R14: Bit 0 disables transmit jabber timer
// R15: PHY regs 0,1,4 reset 3100H/7849H/01E1H
// R16: PHY 2,3 identifier; 5,6 read zero
// R17: PHY 10H..14H reset to documented values
// R18: Software avoids undefined PHY addresses
// R19: Read-clear and self-clear fields behave so
// R20: Software bit-bangs management clock and data
`timescale 1ns/1ps
`default_nettype none
module mac_control_phy_map #(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter int QUANTUM_CYCLES = mac_ctl_pkg::PAUSE_QUANTUM_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] csr_sel,
  input wire logic csr_wr,
  input wire logic csr_rd,
  input wire logic [31:0] csr_wdata,
  output logic [31:0] csr_rdata_ff,
  input wire logic phy_link_in,
  input wire logic phy_fdx_in,
  input wire logic phy_100_in,
  input wire logic phy_10_in,
  input wire logic mgmt_clock_bit,
  input wire logic mgmt_data_out_bit,
  input wire logic mgmt_direction,
  output logic mgmt_data_in_bit_ff,
  output logic tx_buffer_port_ff,
  output logic rx_buffer_port_ff,
  output logic diag_pointer_clear_ff,
  input wire logic desc_ip_csum,
  input wire logic desc_tcp_csum,
  input wire logic desc_udp_csum,
  output logic tx_ip_csum_en_ff,
  output logic tx_tcp_csum_en_ff,
  output logic tx_udp_csum_en_ff,
  output logic rx_csum_report_ff,
  output logic pause_tx_req_ff,
  output logic [15:0] pause_tx_time_ff,
  input wire logic pause_tx_done,
  input wire logic rx_pause_valid,
  input wire logic [15:0] rx_pause_quanta,
  output logic tx_pause_hold_ff,
  input wire logic rx_too_long_raw,
  input wire logic [10:0] rx_frame_len,
  output logic rx_too_long_report_ff,
  output logic watchdog_off_ff,
  output logic jabber_off_ff
);
  import mac_ctl_pkg::*;
  // ******************************************
  // Link status synchroniser
  // ******************************************
  // PHY status comes from the line side, so it is resampled twice
  logic [3:0] phy_meta_ff, phy_sync_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      phy_meta_ff <= 4'h0;
      phy_sync_ff <= 4'h0;
    end else if (ce) begin
      phy_meta_ff <= {phy_link_in, phy_fdx_in, phy_100_in, phy_10_in};
      phy_sync_ff <= phy_meta_ff;
    end
  end
  wire [31:0] mirror_word = MIRROR_FILL | {28'h0, phy_sync_ff}; // R1
  // ******************************************
  // Register decode
  // ******************************************
  wire wr_sample = csr_wr && csr_sel == CSR_SAMPLE_SEL;
  wire wr_feat = csr_wr && csr_sel == CSR_FEATURE;
  wire rd_feat = csr_rd && csr_sel == CSR_FEATURE;
  wire [5:0] sel_code = csr_wdata[SEL_MSB:SEL_LSB];
  wire sel_diag = wr_sample && sel_code == SEL_DIAG_CLR; // R3
  logic [5:0] sel_ff;
  logic csum_desc_ff, ip_all_ff, tcp_all_ff, udp_all_ff;
  logic zero_pause_ff, max_pause_ff, pause_dec_ff, pause_seen_ff;
  logic vlan_ff;
  logic pause_running;
  // ******************************************
  // Pause transmit requests
  // ******************************************
  // A software set in the completion cycle survives the clear
  wire done_zero = pause_tx_done && pause_tx_req_ff &&
    pause_tx_time_ff == PAUSE_TIME_ZERO;
  wire done_max = pause_tx_done && pause_tx_req_ff &&
    pause_tx_time_ff == PAUSE_TIME_MAX;
  wire nxt_zero_pause = (wr_feat && csr_wdata[FEAT_ZERO_PAUSE]) ||
    (!wr_feat && zero_pause_ff && !done_zero); // R7
  wire nxt_max_pause = (wr_feat && csr_wdata[FEAT_MAX_PAUSE]) ||
    (!wr_feat && max_pause_ff && !done_max); // R8
  // Maximum pause goes first when both are pending
  wire [15:0] nxt_pause_time = nxt_max_pause ? PAUSE_TIME_MAX :
    PAUSE_TIME_ZERO; // R8
  // Request drops for one cycle after each completion
  wire nxt_pause_req = (nxt_zero_pause || nxt_max_pause) &&
    !pause_tx_done;
  // ******************************************
  // Pause reception
  // ******************************************
  wire pause_take = rx_pause_valid && pause_dec_ff; // R9
  // New decode in the read cycle wins over the read clear
  wire nxt_pause_seen = pause_take || (pause_seen_ff && !rd_feat); // R10
  wire nxt_dec = wr_feat ? csr_wdata[FEAT_PAUSE_DEC] : pause_dec_ff;
  // ******************************************
  // Feature readback
  // ******************************************
  // Checksum controls are write-only and read back as zero
  wire [31:0] feat_word = {17'h0, zero_pause_ff, max_pause_ff, 2'b00,
    pause_dec_ff, pause_seen_ff, 1'b0, pause_running, vlan_ff, 1'b0,
    watchdog_off_ff, 3'b000, jabber_off_ff}; // R6
  wire [31:0] sample_word = {23'h0, sel_ff, 3'b000};
  wire [31:0] rd_mux = (csr_sel == CSR_PHY_MIRROR) ? mirror_word :
    (csr_sel == CSR_SAMPLE_SEL) ? sample_word :
    (csr_sel == CSR_FEATURE) ? feat_word : 32'h00000000;
  // ******************************************
  // Datapath-facing controls
  // ******************************************
  wire nxt_ip_en = ip_all_ff || (csum_desc_ff && desc_ip_csum); // R4 R5
  wire nxt_tcp_en = tcp_all_ff || (csum_desc_ff && desc_tcp_csum); // R5
  wire nxt_udp_en = udp_all_ff || (csum_desc_ff && desc_udp_csum); // R5
  wire nxt_too_long = rx_too_long_raw &&
    !(vlan_ff && rx_frame_len < VLAN_MAX_LEN); // R12
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      csr_rdata_ff <= 32'h00000000;
      sel_ff <= SEL_RESET;
      diag_pointer_clear_ff <= 1'b0;
      tx_buffer_port_ff <= 1'b0;
      rx_buffer_port_ff <= 1'b0;
    end else if (ce) begin
      csr_rdata_ff <= csr_rd ? rd_mux : 32'h00000000;
      diag_pointer_clear_ff <= sel_diag; // R3
      if (wr_sample && !sel_diag) begin
        sel_ff <= sel_code;
        tx_buffer_port_ff <= sel_code == SEL_TX_BUF; // R2
        rx_buffer_port_ff <= sel_code == SEL_RX_BUF; // R2
      end
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {csum_desc_ff, ip_all_ff, tcp_all_ff, udp_all_ff} <= 4'h0;
      rx_csum_report_ff <= FEAT_RESET[FEAT_RX_CSUM];
      vlan_ff <= FEAT_RESET[FEAT_VLAN];
      watchdog_off_ff <= FEAT_RESET[FEAT_WDOG_OFF];
      jabber_off_ff <= FEAT_RESET[FEAT_JAB_OFF];
    end else if (ce && wr_feat) begin
      csum_desc_ff <= csr_wdata[FEAT_CSUM_DESC]; // R4
      ip_all_ff <= csr_wdata[FEAT_IP_ALL]; // R5
      tcp_all_ff <= csr_wdata[FEAT_TCP_ALL]; // R5
      udp_all_ff <= csr_wdata[FEAT_UDP_ALL]; // R5
      rx_csum_report_ff <= csr_wdata[FEAT_RX_CSUM]; // R6
      vlan_ff <= csr_wdata[FEAT_VLAN]; // R12
      watchdog_off_ff <= csr_wdata[FEAT_WDOG_OFF]; // R13
      jabber_off_ff <= csr_wdata[FEAT_JAB_OFF]; // R14
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      zero_pause_ff <= 1'b0;
      max_pause_ff <= 1'b0;
      pause_dec_ff <= 1'b0;
      pause_seen_ff <= 1'b0;
      pause_tx_req_ff <= 1'b0;
      pause_tx_time_ff <= PAUSE_TIME_ZERO;
      tx_ip_csum_en_ff <= 1'b0;
      tx_tcp_csum_en_ff <= 1'b0;
      tx_udp_csum_en_ff <= 1'b0;
      rx_too_long_report_ff <= 1'b0;
      tx_pause_hold_ff <= 1'b0;
    end else if (ce) begin
      zero_pause_ff <= nxt_zero_pause;
      max_pause_ff <= nxt_max_pause;
      pause_dec_ff <= nxt_dec;
      pause_seen_ff <= nxt_pause_seen;
      pause_tx_req_ff <= nxt_pause_req;
      pause_tx_time_ff <= nxt_pause_time;
      tx_ip_csum_en_ff <= nxt_ip_en;
      tx_tcp_csum_en_ff <= nxt_tcp_en;
      tx_udp_csum_en_ff <= nxt_udp_en;
      rx_too_long_report_ff <= nxt_too_long;
      tx_pause_hold_ff <= pause_running; // R11
    end
  end
  pause_timer #(
    .QUANTUM_CYCLES(QUANTUM_CYCLES)
  ) u_pause_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .load(pause_take), // R9
    .load_quanta(rx_pause_quanta),
    .running_ff(pause_running)
  );
  // ******************************************
  // Management frame slave
  // ******************************************
  // Bits are bit-banged by software, so edges are found by sampling
  mgmt_state_type mg_state_ff;
  logic mdc_prev_ff;
  logic [5:0] mg_cnt_ff;
  logic [15:0] mg_shift_ff;
  logic [1:0] mg_op_ff;
  logic [4:0] mg_reg_ff;
  logic mg_hit_ff;
  logic phy_wr_ff;
  logic [15:0] phy_rdata;
  wire mdc_rise = mgmt_clock_bit && !mdc_prev_ff; // R20
  wire mg_bit = mgmt_data_out_bit;
  wire [15:0] mg_shift_in = {mg_shift_ff[14:0], mg_bit};
  wire mg_read = mg_op_ff == MGMT_OP_READ && mg_hit_ff && mgmt_direction;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mdc_prev_ff <= 1'b0;
      mg_state_ff <= MG_PREAMBLE;
      mg_cnt_ff <= 6'h00;
      mg_shift_ff <= 16'h0000;
      mg_op_ff <= 2'b00;
      mg_reg_ff <= 5'h00;
      mg_hit_ff <= 1'b0;
      phy_wr_ff <= 1'b0;
      mgmt_data_in_bit_ff <= 1'b0;
    end else if (ce) begin
      mdc_prev_ff <= mgmt_clock_bit;
      phy_wr_ff <= 1'b0;
      if (mdc_rise) begin
        case (mg_state_ff)
          MG_PREAMBLE: begin
            mgmt_data_in_bit_ff <= 1'b0;
            if (mg_bit) begin
              if (mg_cnt_ff != 6'(MGMT_PREAMBLE_LEN))
                mg_cnt_ff <= mg_cnt_ff + 6'h01;
            end else if (mg_cnt_ff == 6'(MGMT_PREAMBLE_LEN)) begin
              mg_state_ff <= MG_START;
            end else begin
              mg_cnt_ff <= 6'h00;
            end
          end
          MG_START: begin
            mg_cnt_ff <= 6'h00;
            mg_state_ff <= mg_bit ? MG_OPCODE : MG_PREAMBLE;
          end
          MG_OPCODE: begin
            mg_op_ff <= {mg_op_ff[0], mg_bit};
            mg_cnt_ff <= mg_cnt_ff + 6'h01;
            if (mg_cnt_ff == 6'h01) begin
              mg_cnt_ff <= 6'h00;
              mg_state_ff <= MG_ADDR;
            end
          end
          MG_ADDR: begin
            mg_shift_ff <= mg_shift_in;
            mg_cnt_ff <= mg_cnt_ff + 6'h01;
            if (mg_cnt_ff == 6'h09) begin
              mg_hit_ff <= mg_shift_ff[8:4] == PHY_ADDR;
              mg_reg_ff <= mg_shift_in[4:0];
              mg_cnt_ff <= 6'h00;
              mg_state_ff <= MG_TURN;
            end
          end
          MG_TURN: begin
            mg_cnt_ff <= mg_cnt_ff + 6'h01;
            if (mg_cnt_ff == 6'h01) begin
              mg_shift_ff <= phy_rdata;
              mg_cnt_ff <= 6'h00;
              mg_state_ff <= MG_DATA;
            end
          end
          MG_DATA: begin
            mgmt_data_in_bit_ff <= mg_read && mg_shift_ff[15];
            mg_shift_ff <= mg_read ? {mg_shift_ff[14:0], 1'b0} :
              mg_shift_in;
            mg_cnt_ff <= mg_cnt_ff + 6'h01;
            if (mg_cnt_ff == 6'h0F) begin
              phy_wr_ff <= mg_hit_ff && mg_op_ff == MGMT_OP_WRITE;
              mg_cnt_ff <= 6'h00;
              mg_state_ff <= MG_PREAMBLE;
            end
          end
          default: mg_state_ff <= MG_PREAMBLE;
        endcase
      end
    end
  end
  phy_mgmt_regs u_phy_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .wr_en(phy_wr_ff),
    .addr(mg_reg_ff),
    .wdata(mg_shift_ff),
    .link_up(phy_sync_ff[MIRROR_LINK_BIT]),
    .rdata_ff(phy_rdata)
  );
  // ******************************************
  // Checks
  // ******************************************
  a_mirror_bits: assert property (@(posedge clk) disable iff (sys_rst) // R1
    ce && csr_rd && csr_sel == CSR_PHY_MIRROR
    |=> csr_rdata_ff[3:0] == $past(phy_sync_ff))
    else $error("status mirror does not match link status");
  a_sel_route: assert property (@(posedge clk) disable iff (sys_rst) // R2
    ce && wr_sample && sel_code == SEL_TX_BUF
    |=> tx_buffer_port_ff && !rx_buffer_port_ff)
    else $error("transmit buffer not selected");
  a_diag_pulse: assert property (@(posedge clk) disable iff (sys_rst) // R3
    ce && sel_diag |=> diag_pointer_clear_ff && $stable(sel_ff))
    else $error("diagnostic clear missing or selector changed");
  a_force_csum: assert property (@(posedge clk) disable iff (sys_rst) // R5
    ce && ip_all_ff && !wr_feat |=> tx_ip_csum_en_ff)
    else $error("forced IP checksum not enabled");
  a_zero_clears: assert property (@(posedge clk) disable iff (sys_rst) // R7
    ce && done_zero && !wr_feat |=> !zero_pause_ff)
    else $error("zero pause bit did not self clear");
  a_max_time: assert property (@(posedge clk) disable iff (sys_rst) // R8
    pause_tx_req_ff && max_pause_ff |-> pause_tx_time_ff == PAUSE_TIME_MAX)
    else $error("maximum pause sent with wrong time");
  a_decode_gate: assert property (@(posedge clk) disable iff (sys_rst) // R9
    ce && rx_pause_valid && !pause_dec_ff && !rd_feat
    |=> pause_seen_ff == $past(pause_seen_ff))
    else $error("pause decoded while decoding disabled");
  a_seen_latch: assert property (@(posedge clk) disable iff (sys_rst) // R10
    ce && pause_take |=> pause_seen_ff ##1 (pause_seen_ff || $past(rd_feat)))
    else $error("pause seen flag lost");
  a_vlan_len: assert property (@(posedge clk) disable iff (sys_rst) // R12
    ce && vlan_ff && !wr_feat && rx_frame_len < VLAN_MAX_LEN
    |=> !rx_too_long_report_ff)
    else $error("too long reported below limit in VLAN mode");
endmodule
`default_nettype wire

/* pause_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module pause_link_partner (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tx_req,
  input wire logic [7:0] delay,
  output logic tx_done_ff
);
  // Busy wire time before the frame counts as sent
  logic [7:0] cnt_ff;
  logic busy;
  assign busy = tx_req && !tx_done_ff;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_ff <= 8'h00;
      tx_done_ff <= 1'b0;
    end else begin
      tx_done_ff <= busy && cnt_ff == delay;
      cnt_ff <= (busy && cnt_ff != delay) ? cnt_ff + 8'h01 : 8'h00;
    end
  end
endmodule
`default_nettype wire

/* tb_mac_control_phy_map.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_mac_control_phy_map;
  import mac_ctl_pkg::*;
  logic clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, csr_wr = 1'b0, csr_rd = 1'b0;
  logic [3:0] csr_sel = 4'h0;
  logic [31:0] csr_wdata = 32'h0, csr_rdata_ff;
  logic phy_link_in = 1'b0, phy_fdx_in = 1'b0;
  logic phy_100_in = 1'b0, phy_10_in = 1'b0;
  logic desc_ip_csum = 1'b0, desc_tcp_csum = 1'b0, desc_udp_csum = 1'b0;
  logic pause_tx_done, rx_pause_valid = 1'b0, rx_too_long_raw = 1'b0;
  logic [15:0] rx_pause_quanta = 16'h0, pause_tx_time_ff;
  logic [10:0] rx_frame_len = 11'h0;
  logic [7:0] pdly = 8'h0;
  logic mdc = 1'b0, mdo = 1'b0, mdir = 1'b0;
  logic mgmt_data_in_bit_ff, tx_buffer_port_ff, rx_buffer_port_ff;
  logic diag_pointer_clear_ff, tx_ip_csum_en_ff, tx_tcp_csum_en_ff;
  logic tx_udp_csum_en_ff, rx_csum_report_ff, pause_tx_req_ff;
  logic tx_pause_hold_ff, rx_too_long_report_ff, watchdog_off_ff;
  logic jabber_off_ff;
  int failures = 0, num_checks = 0;
  always #4 clk = ~clk;
  // Short quantum keeps the pause timer runs brief
  mac_control_phy_map #(.QUANTUM_CYCLES(4)) u_dut (.clk, .sys_rst, .ce,
    .csr_sel, .csr_wr, .csr_rd, .csr_wdata, .csr_rdata_ff, .phy_link_in,
    .phy_fdx_in, .phy_100_in, .phy_10_in, .mgmt_clock_bit(mdc),
    .mgmt_data_out_bit(mdo), .mgmt_direction(mdir), .mgmt_data_in_bit_ff,
    .tx_buffer_port_ff, .rx_buffer_port_ff, .diag_pointer_clear_ff,
    .desc_ip_csum, .desc_tcp_csum, .desc_udp_csum, .tx_ip_csum_en_ff,
    .tx_tcp_csum_en_ff, .tx_udp_csum_en_ff, .rx_csum_report_ff,
    .pause_tx_req_ff, .pause_tx_time_ff, .pause_tx_done, .rx_pause_valid,
    .rx_pause_quanta, .tx_pause_hold_ff, .rx_too_long_raw, .rx_frame_len,
    .rx_too_long_report_ff, .watchdog_off_ff, .jabber_off_ff);
  pause_link_partner u_partner (.clk, .sys_rst, .tx_req(pause_tx_req_ff),
    .delay(pdly), .tx_done_ff(pause_tx_done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [31:0] d);
    @(posedge clk);
    csr_sel <= s;
    csr_wdata <= d;
    csr_wr <= 1'b1;
    @(posedge clk);
    csr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] s, input logic [31:0] exp);
    @(posedge clk);
    csr_sel <= s;
    csr_rd <= 1'b1;
    @(posedge clk);
    csr_rd <= 1'b0;
    #1;
    chk(csr_rdata_ff, exp);
  endtask
  task automatic tx_pause(input int b, input logic [15:0] t);
    wr(CSR_FEATURE, 32'h1 << b);
    for (int i = 0; i < 40 && pause_tx_req_ff !== 1'b1; i++) @(posedge clk);
    chk({pause_tx_req_ff, pause_tx_time_ff}, {1'b1, t});
    for (int i = 0; i < 40 && pause_tx_req_ff !== 1'b0; i++) @(posedge clk);
    rd(CSR_FEATURE, 32'h0);
  endtask
  // One management bit: data set while clock low, rise seen two edges on
  task automatic mbit(input logic b, output logic q);
    @(posedge clk);
    mdc <= 1'b0;
    mdo <= b;
    mdir <= 1'b1;
    @(posedge clk);
    mdc <= 1'b1;
    @(posedge clk);
    #1;
    q = mgmt_data_in_bit_ff;
  endtask
  task automatic mread(input logic [4:0] r, input logic [15:0] exp);
    logic q;
    logic [15:0] w;
    logic [47:0] hdr;
    hdr = {32'hFFFFFFFF, 4'b0110, 5'h01, r, 2'b00};
    for (int i = 47; i >= 0; i--) mbit(hdr[i], q);
    for (int i = 0; i < 16; i++) begin
      mbit(1'b0, q);
      w = {w[14:0], q};
    end
    chk(w, exp);
  endtask
  task automatic pulse(input logic [15:0] q);
    @(posedge clk);
    rx_pause_quanta <= q;
    rx_pause_valid <= 1'b1;
    @(posedge clk);
    rx_pause_valid <= 1'b0;
  endtask
  task automatic results;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    phy_link_in <= 1'b1;
    phy_100_in <= 1'b1;
    repeat (4) @(posedge clk);
    rd(CSR_PHY_MIRROR, 32'hFFFFFE0A);
    wr(CSR_SAMPLE_SEL, 32'h190);
    rd(CSR_SAMPLE_SEL, 32'h190);
    chk(tx_buffer_port_ff, 1'b1);
    wr(CSR_SAMPLE_SEL, 32'h1C0);
    #1;
    chk(diag_pointer_clear_ff, 1'b1);
    rd(CSR_SAMPLE_SEL, 32'h190);
    wr(CSR_SAMPLE_SEL, 32'h1A8);
    rd(CSR_SAMPLE_SEL, 32'h1A8);
    chk(rx_buffer_port_ff, 1'b1);
    desc_ip_csum <= 1'b1;
    wr(CSR_FEATURE, 32'h80000000);
    repeat (2) @(posedge clk);
    chk({tx_ip_csum_en_ff, tx_tcp_csum_en_ff, tx_udp_csum_en_ff}, 3'h4);
    wr(CSR_FEATURE, 32'h78000451);
    rx_too_long_raw <= 1'b1;
    rx_frame_len <= 11'h5F5;
    repeat (3) @(posedge clk);
    chk({tx_tcp_csum_en_ff, tx_udp_csum_en_ff, rx_csum_report_ff}, 3'h7);
    chk({watchdog_off_ff, jabber_off_ff, rx_too_long_report_ff}, 3'h6);
    rx_frame_len <= 11'h5F6;
    repeat (3) @(posedge clk);
    chk(rx_too_long_report_ff, 1'b1);
    rd(CSR_FEATURE, 32'h451);
    pdly <= 8'h0;
    tx_pause(FEAT_MAX_PAUSE, PAUSE_TIME_MAX);
    pdly <= 8'hA;
    tx_pause(FEAT_ZERO_PAUSE, PAUSE_TIME_ZERO);
    chk({watchdog_off_ff, jabber_off_ff}, 2'h0);
    pulse(16'h2);
    rd(CSR_FEATURE, 32'h0);
    wr(CSR_FEATURE, 32'h400);
    pulse(16'h2);
    rd(CSR_FEATURE, 32'h680);
    chk(tx_pause_hold_ff, 1'b1);
    rd(CSR_FEATURE, 32'h480);
    repeat (12) @(posedge clk);
    rd(CSR_FEATURE, 32'h400);
    chk(tx_pause_hold_ff, 1'b0);
    mread(PHY_BASIC_CONTROL, BASIC_CONTROL_RESET);
    mread(VENDOR_CONFIG_STATUS, VENDOR_STATUS_RESET);
    results();
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    $display("CHECK FAILED t=%0t watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
